// ===== aux_supply_key_register_bank.sv
/*
 * register bank of the auxiliary supply switching unit: key protection,
 * lock bit, switch state readback, mode/priority/okay control.
 * assumes a same-clock register port; monitor and power-down inputs are pins.
 */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// - writing A5h to the key byte enables protected register writes
// - a byte write of a wrong key disables protected writes
// - a word write with a wrong key byte also disables writes
// - protected writes other than control zero are dropped while disabled
// - the key byte always reads back 96h
// - key writes take effect only while the lock bit is clear or is cleared by the same write
// - one write may clear the lock and give the key together
// - the lock bit may be cleared by software, never set
// - hardware sets the lock bit after core power-down
// - while locked the system runs from primary or first auxiliary
// - bits 3..1 report second aux, first aux, primary switch closed
// - reserved bits read as zero
// - only the second and third control registers are key protected
// - mode bit zero means hardware monitoring, one means software
// - okay flag follows monitor in hardware mode, software in software mode
// - priority bit set prefers second auxiliary over first
module aux_supply_key_register_bank (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] byte_en,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic [2:0] monitor_ok_pin,
    input wire logic core_power_down_pin,
    output logic [2:0] switch_closed,
    output logic [2:0] okay_out,
    output logic protected_writable
);
    supply_regs_pkg::bus_req_s req;
    logic [2:0] mon_sync1;
    logic [2:0] mon_sync2;
    logic pd_sync1;
    logic pd_sync2;
    logic lock;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] chg2;
    logic [15:0] chg3;
    logic [15:0] conv;
    logic [15:0] flags;
    logic [15:0] enables;
    logic [15:0] vector;
    logic write_enabled;
    logic [2:0] switch_state;
    logic wr_ctrl0;
    logic key_write;
    logic lock_clear_now;
    logic prot_ok;
    logic [15:0] bmask;
    logic [15:0] next_ctrl1;
    logic [15:0] read_word;

    // bus request bundle
    assign req = '{wr: wr, rd: rd, addr: addr, byte_en: byte_en, wdata: wdata};

    // byte lane mask from enables
    assign bmask = {{8{req.byte_en[1]}}, {8{req.byte_en[0]}}};

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            mon_sync1 <= 3'h0;
            mon_sync2 <= 3'h0;
            pd_sync1 <= 1'b0;
            pd_sync2 <= 1'b0;
        end else begin
            mon_sync1 <= monitor_ok_pin;
            mon_sync2 <= mon_sync1;
            pd_sync1 <= core_power_down_pin;
            pd_sync2 <= pd_sync1;
        end
    end

    // first control register decode
    assign wr_ctrl0 = req.wr && req.addr == supply_regs_pkg::OFF_CTRL0;
    // any upper-byte write to the first control register is a key write
    assign key_write = wr_ctrl0 && req.byte_en[1];
    assign lock_clear_now = wr_ctrl0 && req.byte_en[0] && !req.wdata[supply_regs_pkg::LOCK_POS];
    assign prot_ok = write_enabled;

    supply_key_gate u_key (
        .clk(clk),
        .reset(reset),
        .key_write(key_write),
        .key_value(req.wdata[15:8]),
        .lock_clear_now(lock_clear_now),
        .locked(lock),
        .write_enabled(write_enabled)
    );

    // lock bit
    always_ff @(posedge clk) begin
        if (reset) begin
            lock <= supply_regs_pkg::RST_CTRL0[supply_regs_pkg::LOCK_POS];
        end else if (pd_sync2) begin
            // power-down sets lock, wins over clear
            lock <= 1'b1;
        end else if (lock_clear_now) begin
            // software may only clear
            // the first control register is never key gated, so the clear and
            // the key land together in one write
            lock <= 1'b0;
        end
    end

    always_comb begin
        next_ctrl1 = ctrl1;
        if (req.wr && req.addr == supply_regs_pkg::OFF_CTRL1 && prot_ok) begin
            next_ctrl1 = (ctrl1 & ~(bmask & supply_regs_pkg::CTRL1_WMASK))
                | (req.wdata & bmask & supply_regs_pkg::CTRL1_WMASK);
        end
        for (int i = 0; i < 3; i++) begin
            if (!next_ctrl1[supply_regs_pkg::MODE_LSB + i]) begin
                next_ctrl1[supply_regs_pkg::OK_LSB + i] = mon_sync2[i];
            end
        end
    end

    // second control register
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl1 <= supply_regs_pkg::RST_CTRL1;
        end else begin
            ctrl1 <= next_ctrl1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl2 <= supply_regs_pkg::RST_CTRL2;
        end else if (req.wr && req.addr == supply_regs_pkg::OFF_CTRL2 && prot_ok) begin
            ctrl2 <= (ctrl2 & ~(bmask & supply_regs_pkg::CTRL2_WMASK))
                | (req.wdata & bmask & supply_regs_pkg::CTRL2_WMASK);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            chg2 <= supply_regs_pkg::RST_CHG;
            chg3 <= supply_regs_pkg::RST_CHG;
            conv <= supply_regs_pkg::RST_PLAIN;
            flags <= supply_regs_pkg::RST_PLAIN;
            enables <= supply_regs_pkg::RST_PLAIN;
            vector <= supply_regs_pkg::RST_PLAIN;
        end else if (req.wr) begin
            case (req.addr)
                supply_regs_pkg::OFF_CHG2: chg2 <= (chg2 & ~bmask) | (req.wdata & bmask);
                supply_regs_pkg::OFF_CHG3: chg3 <= (chg3 & ~bmask) | (req.wdata & bmask);
                supply_regs_pkg::OFF_CONV: conv <= (conv & ~bmask) | (req.wdata & bmask);
                supply_regs_pkg::OFF_FLAGS: flags <= (flags & ~bmask) | (req.wdata & bmask);
                supply_regs_pkg::OFF_ENABLES: enables <= (enables & ~bmask) | (req.wdata & bmask);
                supply_regs_pkg::OFF_VECTOR: vector <= (vector & ~bmask) | (req.wdata & bmask);
                default: ;
            endcase
        end
    end

    supply_switch_select u_sel (
        .clk(clk),
        .reset(reset),
        .okay(ctrl1[2:0]),
        .prefer_second(ctrl1[supply_regs_pkg::PRIO_POS]),
        .locked(lock),
        .switch_state(switch_state)
    );

    // read mux
    always_comb begin
        case (req.addr)
            supply_regs_pkg::OFF_CTRL0: read_word = {supply_regs_pkg::KEY_READ, 4'h0,
                switch_state, lock};
            supply_regs_pkg::OFF_CTRL1: read_word = ctrl1 & supply_regs_pkg::CTRL1_WMASK;
            supply_regs_pkg::OFF_CTRL2: read_word = ctrl2 & supply_regs_pkg::CTRL2_WMASK;
            supply_regs_pkg::OFF_CHG2: read_word = chg2;
            supply_regs_pkg::OFF_CHG3: read_word = chg3;
            supply_regs_pkg::OFF_CONV: read_word = conv;
            supply_regs_pkg::OFF_FLAGS: read_word = flags;
            supply_regs_pkg::OFF_ENABLES: read_word = enables;
            supply_regs_pkg::OFF_VECTOR: read_word = vector;
            default: read_word = 16'h0000;
        endcase
    end

    // registered read data and outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 16'h0000;
            switch_closed <= 3'h1;
            okay_out <= 3'h0;
            protected_writable <= 1'b0;
        end else begin
            rdata <= req.rd ? read_word : 16'h0000;
            switch_closed <= switch_state;
            okay_out <= ctrl1[2:0];
            protected_writable <= write_enabled;
        end
    end

    chk_key_enable: assert property (@(posedge clk) disable iff (reset)
        key_write && (!lock || lock_clear_now) && wdata[15:8] == 8'hA5 |=> write_enabled)
        else $error("correct key did not enable writes");
    chk_word_wrong: assert property (@(posedge clk) disable iff (reset)
        wr_ctrl0 && byte_en == 2'b11 && !lock && wdata[15:8] != 8'hA5 |=> !write_enabled)
        else $error("word write with wrong key kept enable");
    chk_drop_write: assert property (@(posedge clk) disable iff (reset)
        wr && addr == supply_regs_pkg::OFF_CTRL2 && !write_enabled |=> $stable(ctrl2))
        else $error("protected write while disabled changed register");
    chk_key_read: assert property (@(posedge clk) disable iff (reset)
        rd && addr == supply_regs_pkg::OFF_CTRL0 |=> rdata[15:8] == 8'h96 && rdata[7:4] == 4'h0)
        else $error("key byte or reserved bits read wrong");
    chk_lock_clear: assert property (@(posedge clk) disable iff (reset)
        !lock && !pd_sync2 |=> !lock)
        else $error("lock bit set without power-down");
    chk_pd_lock: assert property (@(posedge clk) disable iff (reset)
        pd_sync2 |=> lock)
        else $error("lock not set after power-down");
    chk_sw_okay: assert property (@(posedge clk) disable iff (reset)
        ctrl1[8] && !(wr && addr == supply_regs_pkg::OFF_CTRL1) |=> $stable(ctrl1[0]))
        else $error("software okay flag changed by hardware");
    chk_hw_okay: assert property (@(posedge clk) disable iff (reset)
        !next_ctrl1[9] |=> ctrl1[1] == $past(mon_sync2[1]))
        else $error("hardware okay flag not following monitor");
    chk_sw_read: assert property (@(posedge clk) disable iff (reset)
        rd && addr == supply_regs_pkg::OFF_CTRL0 |=> rdata[3:1] == $past(switch_state))
        else $error("switch state readback mismatch");
endmodule

// ===== supply_regs_pkg.sv
/*
 * package for the auxiliary supply register bank: offsets, field positions,
 * reset values and the bus request carrier.
 * assumes a 16-bit register port with byte addressing and byte enables.
 */
package supply_regs_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL0 = 5'h00;
    localparam logic [4:0] OFF_CTRL1 = 5'h02;
    localparam logic [4:0] OFF_CTRL2 = 5'h04;
    localparam logic [4:0] OFF_CHG2 = 5'h12;
    localparam logic [4:0] OFF_CHG3 = 5'h14;
    localparam logic [4:0] OFF_CONV = 5'h16;
    localparam logic [4:0] OFF_FLAGS = 5'h1A;
    localparam logic [4:0] OFF_ENABLES = 5'h1C;
    localparam logic [4:0] OFF_VECTOR = 5'h1E;
    localparam logic [7:0] KEY_UNLOCK = 8'hA5;
    localparam logic [7:0] KEY_READ = 8'h96;
    localparam int LOCK_POS = 0;
    localparam int SW_LSB = 1;
    localparam int MODE_LSB = 8;
    localparam int OK_LSB = 0;
    localparam int PRIO_POS = 3;
    localparam logic [15:0] CTRL1_WMASK = 16'h070F;
    localparam logic [15:0] CTRL2_WMASK = 16'h3777;
    localparam logic [15:0] RST_CTRL0 = 16'h9601;
    localparam logic [15:0] RST_CTRL1 = 16'h0000;
    localparam logic [15:0] RST_CTRL2 = 16'h0000;
    localparam logic [15:0] RST_CHG = 16'h5A00;
    localparam logic [15:0] RST_PLAIN = 16'h0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [1:0] byte_en;
        logic [15:0] wdata;
    } bus_req_s;
endpackage

// ===== supply_key_gate.sv
/*
 * key gate: holds the write-enable state set by the unlock key.
 * assumes writes to the first control register are flagged by the caller.
 */
`timescale 1ns/1ps
module supply_key_gate (
    input wire logic clk,
    input wire logic reset,
    input wire logic key_write,
    input wire logic [7:0] key_value,
    input wire logic lock_clear_now,
    input wire logic locked,
    output logic write_enabled
);
    // key sets enable, only while unlocked or in the write that clears the lock
    always_ff @(posedge clk) begin
        if (reset) begin
            write_enabled <= 1'b0;
        end else if (key_write && (!locked || lock_clear_now)) begin
            write_enabled <= (key_value == supply_regs_pkg::KEY_UNLOCK);
        end
    end

    chk_reset_disabled: assert property (@(posedge clk) $fell(reset) |-> !write_enabled)
        else $error("write enable not clear after reset");
    chk_wrong_key: assert property (@(posedge clk) disable iff (reset)
        key_write && !locked && key_value != supply_regs_pkg::KEY_UNLOCK
        |=> !write_enabled)
        else $error("wrong key left writes enabled");
    chk_locked_key: assert property (@(posedge clk) disable iff (reset)
        locked && !lock_clear_now |=> $stable(write_enabled))
        else $error("key took effect while locked");
endmodule

// ===== supply_switch_select.sv
/*
 * switch selector: picks which supply switch is closed from okay flags,
 * priority and lock; output registered, one-hot.
 * assumes okay flags come from the register bank on the same clock.
 */
`timescale 1ns/1ps
module supply_switch_select (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] okay,
    input wire logic prefer_second,
    input wire logic locked,
    output logic [2:0] switch_state
);
    logic [2:0] next_switch_state;

    always_comb begin
        next_switch_state = 3'h0;
        if (okay[0] || locked && !okay[1]) begin
            next_switch_state = 3'h1;
        end else if (locked) begin
            next_switch_state = 3'h2;
        end else if (okay[2] && (prefer_second || !okay[1])) begin
            next_switch_state = 3'h4;
        end else if (okay[1]) begin
            next_switch_state = 3'h2;
        end else begin
            next_switch_state = 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            switch_state <= 3'h1;
        end else begin
            switch_state <= next_switch_state;
        end
    end

    chk_locked_supply: assert property (@(posedge clk) disable iff (reset)
        locked |=> !switch_state[2])
        else $error("locked system switched to second auxiliary supply");
    chk_priority_pick: assert property (@(posedge clk) disable iff (reset)
        !locked && !okay[0] && okay[1] && okay[2] |=> switch_state[2] == $past(prefer_second))
        else $error("auxiliary priority not respected");
endmodule

// ===== aux_supply_key_register_bank_test.sv
/*
 * self-checking bench for the auxiliary supply register bank.
 * assumes the bank's ports as declared and a 20 MHz clock.
 */
`timescale 1ns/1ps
module aux_supply_key_register_bank_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] byte_en = 2'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] monitor_ok_pin = 3'h7;
    logic core_power_down_pin = 1'b0;
    logic [15:0] rdata;
    logic [2:0] switch_closed;
    logic [2:0] okay_out;
    logic protected_writable;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'hA6B2;
    logic [15:0] m1 = 16'h0007;
    logic [15:0] m2 = 16'h0000;
    logic [15:0] seen;
    logic [15:0] e;
    logic [1:0] be;
    logic [4:0] ra [10] = '{5'h00, 5'h02, 5'h04, 5'h12, 5'h14, 5'h16, 5'h1A, 5'h1C, 5'h1E, 5'h08};
    logic [15:0] rv [10] = '{16'h9603, 16'h0007, 16'h0000, 16'h5A00, 16'h5A00, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    aux_supply_key_register_bank aux_supply_key_register_bank_i (
        .clk(clk),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .byte_en(byte_en),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .monitor_ok_pin(monitor_ok_pin),
        .core_power_down_pin(core_power_down_pin),
        .switch_closed(switch_closed),
        .okay_out(okay_out),
        .protected_writable(protected_writable)
    );

    // clock and hang guard
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            give_verdict();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
        input logic [1:0] b);
        return {b[1] ? n[15:8] : o[15:8], b[0] ? n[7:0] : o[7:0]};
    endfunction

    // okay flags follow software in software mode, the monitor otherwise
    function automatic logic [15:0] exp_ctrl1(input logic [15:0] m, input logic [2:0] mon);
        return (m & 16'h0708) | {13'h0000, (m[10:8] & m[2:0]) | (~m[10:8] & mon)};
    endfunction

    function automatic logic [2:0] exp_sw(input logic [2:0] ok, input logic p, input logic lk);
        if (lk || ok[0]) begin
            return ok[0] ? 3'h1 : 3'h2;
        end
        if (p) begin
            return ok[2] ? 3'h4 : (ok[1] ? 3'h2 : 3'h1);
        end
        return ok[1] ? 3'h2 : (ok[2] ? 3'h4 : 3'h1);
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d, input logic [1:0] b);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        byte_en <= b;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        idle(8);
        check({15'h0000, protected_writable}, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            rd_reg(ra[i], seen);
            check(seen, rv[i]);
        end
        wr_reg(supply_regs_pkg::OFF_CTRL1, 16'h070F, 2'h3);
        wr_reg(supply_regs_pkg::OFF_CTRL2, 16'h3777, 2'h3);
        rd_reg(supply_regs_pkg::OFF_CTRL1, seen);
        check(seen, 16'h0007);
        rd_reg(supply_regs_pkg::OFF_CTRL2, seen);
        check(seen, 16'h0000);
        wr_reg(supply_regs_pkg::OFF_CONV, 16'hBEEF, 2'h3);
        rd_reg(supply_regs_pkg::OFF_CONV, seen);
        check(seen, 16'hBEEF);
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'hA501, 2'h3);
        idle(3);
        check({15'h0000, protected_writable}, 16'h0000);
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'hA500, 2'h3);
        idle(3);
        check({15'h0000, protected_writable}, 16'h0001);
        rd_reg(supply_regs_pkg::OFF_CTRL0, seen);
        check(seen, 16'h9602);
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'hA500, 2'h3);
        rd_reg(supply_regs_pkg::OFF_CTRL0, seen);
        check(seen, 16'h9602);
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'hA501, 2'h3);
        rd_reg(supply_regs_pkg::OFF_CTRL0, seen);
        check(seen, 16'h9602);
        // random lane writes to the two protected control registers
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            be = rnd[20:19];
            @(posedge clk);
            monitor_ok_pin <= rnd[18:16];
            m1 = merge(m1, rnd[15:0], be) & supply_regs_pkg::CTRL1_WMASK;
            wr_reg(supply_regs_pkg::OFF_CTRL1, rnd[15:0], be);
            idle(3);
            rd_reg(supply_regs_pkg::OFF_CTRL1, seen);
            e = exp_ctrl1(m1, rnd[18:16]);
            check(seen, e);
            check({13'h0000, okay_out}, {13'h0000, e[2:0]});
            m1 = e;
            rnd = lfsr(rnd);
            m2 = merge(m2, rnd[15:0], rnd[17:16]) & supply_regs_pkg::CTRL2_WMASK;
            wr_reg(supply_regs_pkg::OFF_CTRL2, rnd[15:0], rnd[17:16]);
            rd_reg(supply_regs_pkg::OFF_CTRL2, seen);
            check(seen, m2);
        end
        // every okay and priority combination in software mode
        for (int i = 0; i < 16; i++) begin
            wr_reg(supply_regs_pkg::OFF_CTRL1, {8'h07, 4'h0, i[3:0]}, 2'h3);
            idle(4);
            e = {8'h96, 4'h0, exp_sw(i[2:0], i[3], 1'b0), 1'b0};
            check({13'h0000, switch_closed}, {13'h0000, e[3:1]});
            rd_reg(supply_regs_pkg::OFF_CTRL0, seen);
            check(seen, e);
        end
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'h1200, 2'h2);
        idle(3);
        check({15'h0000, protected_writable}, 16'h0000);
        wr_reg(supply_regs_pkg::OFF_CTRL1, 16'h0000, 2'h3);
        rd_reg(supply_regs_pkg::OFF_CTRL1, seen);
        check(seen, 16'h070F);
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'hA500, 2'h3);
        idle(3);
        check({15'h0000, protected_writable}, 16'h0001);
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'h3300, 2'h3);
        idle(3);
        check({15'h0000, protected_writable}, 16'h0000);
        wr_reg(supply_regs_pkg::OFF_CTRL0, 16'hA500, 2'h3);
        wr_reg(supply_regs_pkg::OFF_CTRL1, 16'h0706, 2'h3);
        @(posedge clk);
        core_power_down_pin <= 1'b1;
        idle(4);
        core_power_down_pin <= 1'b0;
        idle(6);
        rd_reg(supply_regs_pkg::OFF_CTRL0, seen);
        check(seen, {8'h96, 4'h0, exp_sw(3'h6, 1'b0, 1'b1), 1'b1});
        check({13'h0000, switch_closed}, 16'h0002);
        give_verdict();
    end
endmodule
